// *** ss_params_defines.svh ***
// offsets, reset values, limits and answer codes of the parameter bank
`ifndef SS_PARAMS_DEFINES_SVH
`define SS_PARAMS_DEFINES_SVH
// parameter numbers
`define PN_STATION    16'h3e80
`define PN_RATE       16'h3ec0
`define PN_PARITY     16'h3f00
`define PN_RUN        16'h4600
`define PN_HOLD       16'h4740
`define PN_CLEAR      16'h47c0
`define PN_TRIP       16'h49c0
`define PN_PRESET     16'h4b00
`define PN_TORQUE     16'h4d80
`define PN_FIN_CUR    16'h4dc0
`define PN_FIN_SPD    16'h4e00
// reset values
`define RST_STATION   16'h0001
`define RST_RATE      16'h0001
`define RST_PARITY    16'h0001
`define RST_PRESET    16'h0000
`define RST_BIT       1'h0
// value limits
`define VAL_ZERO      16'h0000
`define STATION_MIN   16'h0001
`define STATION_MAX   16'h0020
`define RATE_MAX      16'h0004
`define PARITY_MAX    16'h0002
`define BIT_MAX       16'h0001
`define PARITY_NONE   16'h0000
`define PARITY_EVEN   16'h0001
`define PARITY_ODD    16'h0002
// exception codes
`define EXC_NONE      8'h00
`define EXC_ADDR      8'h02
`define EXC_VALUE     8'h03
`endif

// *** ss_params_pkg.sv ***
// types shared by the parameter bank and its users
package ss_params_pkg;
    typedef struct packed {
        logic        write;
        logic [7:0]  station;
        logic [15:0] param;
        logic [15:0] wdata;
    } req_s;

    typedef struct packed {
        logic        err;
        logic [7:0]  code;
        logic [15:0] rdata;
    } rsp_s;

    typedef enum logic {
        CLR_IDLE  = 1'b0,
        CLR_ARMED = 1'b1
    } clr_state_e;
endpackage

// *** soft_starter_modbus_params.sv ***
// serial parameter bank of the soft starter: link settings, commands, options
`timescale 1ns/1ps
`include "ss_params_defines.svh"

module soft_starter_modbus_params (
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,
    input  wire logic                 req_valid,
    input  wire ss_params_pkg::req_s  req,
    output logic                      rsp_valid,
    output ss_params_pkg::rsp_s       rsp,
    input  wire logic                 remote_trip_enable,
    input  wire logic                 ramp_active,
    input  wire logic                 start_time_done,
    input  wire logic                 current_below_limit,
    input  wire logic                 at_full_speed,
    output logic [15:0]               station_number,
    output logic [15:0]               bit_rate_code,
    output logic                      parity_enable,
    output logic                      parity_odd,
    output logic                      two_stop_bits,
    output logic                      motor_run,
    output logic                      ramp_freeze,
    output logic                      ramp_complete,
    output logic                      fault_reset,
    output logic                      tripped,
    output logic [15:0]               preset_code,
    output logic                      preset_load,
    output logic                      auto_torque,
    output logic                      finish_on_current,
    output logic                      finish_on_speed
);

    // ------------------------------------------------------------
    // value checks
    // ------------------------------------------------------------
    function automatic logic fits(input logic [15:0] v, input logic [15:0] lo,
                                  input logic [15:0] hi);
        fits = (v >= lo) && (v <= hi);
    endfunction

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    logic [15:0] station_ff, rate_ff, parity_ff, preset_ff;
    logic        run_ff, hold_ff, clr_cmd_ff, trip_cmd_ff;
    logic        torque_ff, fin_cur_ff, fin_spd_ff;
    logic [15:0] d;
    logic        hit, sel_station, sel_rate, sel_parity, sel_run, sel_hold, sel_clr;
    logic        sel_trip, sel_preset, sel_torque, sel_cur, sel_spd, known, val_ok, wr_ok;

    // only our own station is served; others get silence
    assign d           = req.wdata;
    assign hit         = req_valid && ({8'h00, req.station} == station_ff);
    assign sel_station = req.param == `PN_STATION;
    assign sel_rate    = req.param == `PN_RATE;
    assign sel_parity  = req.param == `PN_PARITY;
    assign sel_run     = req.param == `PN_RUN;
    assign sel_hold    = req.param == `PN_HOLD;
    assign sel_clr     = req.param == `PN_CLEAR;
    assign sel_trip    = req.param == `PN_TRIP;
    assign sel_preset  = req.param == `PN_PRESET;
    assign sel_torque  = req.param == `PN_TORQUE;
    assign sel_cur     = req.param == `PN_FIN_CUR;
    assign sel_spd     = req.param == `PN_FIN_SPD;
    assign known = sel_station | sel_rate | sel_parity | sel_run | sel_hold | sel_clr |
                   sel_trip | sel_preset | sel_torque | sel_cur | sel_spd;

    // range of each field; bad values are refused and the old value kept
    assign val_ok = sel_station ? fits(d, `STATION_MIN, `STATION_MAX) :
                    sel_rate    ? fits(d, `VAL_ZERO, `RATE_MAX) :
                    sel_parity  ? fits(d, `VAL_ZERO, `PARITY_MAX) :
                    sel_preset  ? 1'b1 :
                    fits(d, `VAL_ZERO, `BIT_MAX);
    assign wr_ok = hit && req.write && known && val_ok;

    // ------------------------------------------------------------
    // next values of the fields
    // ------------------------------------------------------------
    logic [15:0] nxt_station, nxt_rate, nxt_parity, nxt_preset;
    logic        nxt_run, nxt_hold, nxt_clr_cmd, nxt_trip_cmd, nxt_torque, nxt_fin_cur;
    logic        nxt_fin_spd;

    // fields hold until a valid write replaces them
    assign nxt_station  = (wr_ok && sel_station) ? d : station_ff;
    assign nxt_rate     = (wr_ok && sel_rate) ? d : rate_ff;
    assign nxt_parity   = (wr_ok && sel_parity) ? d : parity_ff;
    assign nxt_preset   = (wr_ok && sel_preset) ? d : preset_ff;
    assign nxt_run      = (wr_ok && sel_run) ? d[0] : run_ff;
    assign nxt_hold     = (wr_ok && sel_hold) ? d[0] : hold_ff;
    assign nxt_clr_cmd  = (wr_ok && sel_clr) ? d[0] : clr_cmd_ff;
    assign nxt_trip_cmd = (wr_ok && sel_trip) ? d[0] : trip_cmd_ff;
    assign nxt_torque   = (wr_ok && sel_torque) ? d[0] : torque_ff;
    assign nxt_fin_cur  = (wr_ok && sel_cur) ? d[0] : fin_cur_ff;
    assign nxt_fin_spd  = (wr_ok && sel_spd) ? d[0] : fin_spd_ff;

    // field storage
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            station_ff  <= `RST_STATION;
            rate_ff     <= `RST_RATE;
            parity_ff   <= `RST_PARITY;
            preset_ff   <= `RST_PRESET;
            run_ff      <= `RST_BIT;
            hold_ff     <= `RST_BIT;
            clr_cmd_ff  <= `RST_BIT;
            trip_cmd_ff <= `RST_BIT;
            torque_ff   <= `RST_BIT;
            fin_cur_ff  <= `RST_BIT;
            fin_spd_ff  <= `RST_BIT;
        end else begin
            station_ff  <= nxt_station;
            rate_ff     <= nxt_rate;
            parity_ff   <= nxt_parity;
            preset_ff   <= nxt_preset;
            run_ff      <= nxt_run;
            hold_ff     <= nxt_hold;
            clr_cmd_ff  <= nxt_clr_cmd;
            trip_cmd_ff <= nxt_trip_cmd;
            torque_ff   <= nxt_torque;
            fin_cur_ff  <= nxt_fin_cur;
            fin_spd_ff  <= nxt_fin_spd;
        end
    end

    // ------------------------------------------------------------
    // answer path
    // ------------------------------------------------------------
    logic [15:0]         rd_mux;
    ss_params_pkg::rsp_s nxt_rsp, rsp_ff;
    logic                rsp_valid_ff;

    // readback shows stored state; one-bit fields zero extended
    assign rd_mux = sel_station ? station_ff :
                    sel_rate    ? rate_ff :
                    sel_parity  ? parity_ff :
                    sel_preset  ? preset_ff :
                    sel_run     ? {15'h0000, run_ff} :
                    sel_hold    ? {15'h0000, hold_ff} :
                    sel_clr     ? {15'h0000, clr_cmd_ff} :
                    sel_trip    ? {15'h0000, trip_cmd_ff} :
                    sel_torque  ? {15'h0000, torque_ff} :
                    sel_cur     ? {15'h0000, fin_cur_ff} :
                    sel_spd     ? {15'h0000, fin_spd_ff} : `VAL_ZERO;
    assign nxt_rsp.err   = !known || (req.write && !val_ok);
    assign nxt_rsp.code  = !known ? `EXC_ADDR :
                           (req.write && !val_ok) ? `EXC_VALUE : `EXC_NONE;
    assign nxt_rsp.rdata = (req.write || !known) ? `VAL_ZERO : rd_mux;

    // answer one cycle after the request, held until the next one
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_valid_ff <= 1'b0;
            rsp_ff       <= '0;
        end else begin
            rsp_valid_ff <= hit;
            rsp_ff       <= hit ? nxt_rsp : rsp_ff;
        end
    end

    // ------------------------------------------------------------
    // commands and derived controls
    // ------------------------------------------------------------
    ss_params_pkg::clr_state_e clr_state_ff, nxt_clr_state;
    logic nxt_fault_reset, fault_reset_ff, nxt_tripped, tripped_ff, preset_load_ff;
    logic early_end, nxt_complete, complete_ff, par_en_ff, par_odd_ff, two_stop_ff;

    // reset fires on the falling half of a high-then-low pulse
    assign nxt_clr_state   = clr_cmd_ff ? ss_params_pkg::CLR_ARMED : ss_params_pkg::CLR_IDLE;
    assign nxt_fault_reset = (clr_state_ff == ss_params_pkg::CLR_ARMED) &&
                             !clr_cmd_ff;
    // trip set wins over a reset in the same cycle; the run command plays no part
    assign nxt_tripped = (remote_trip_enable && trip_cmd_ff) ||
                         (tripped_ff && !fault_reset_ff);
    // hold blocks every way of finishing, current below limit included
    assign early_end    = (fin_cur_ff && current_below_limit) ||
                          (fin_spd_ff && at_full_speed);
    assign nxt_complete = ramp_active && !hold_ff &&
                          (start_time_done || early_end);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            clr_state_ff   <= ss_params_pkg::CLR_IDLE;
            fault_reset_ff <= 1'b0;
            tripped_ff     <= 1'b0;
            preset_load_ff <= 1'b0;
            complete_ff    <= 1'b0;
            par_en_ff      <= (`RST_PARITY != `PARITY_NONE);
            par_odd_ff     <= (`RST_PARITY == `PARITY_ODD);
            two_stop_ff    <= (`RST_PARITY == `PARITY_NONE);
        end else begin
            clr_state_ff   <= nxt_clr_state;
            fault_reset_ff <= nxt_fault_reset;
            tripped_ff     <= nxt_tripped;
            preset_load_ff <= wr_ok && sel_preset;
            complete_ff    <= nxt_complete;
            par_en_ff      <= nxt_parity != `PARITY_NONE;
            par_odd_ff     <= nxt_parity == `PARITY_ODD;
            two_stop_ff    <= nxt_parity == `PARITY_NONE;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rsp_valid         = rsp_valid_ff;
    assign rsp               = rsp_ff;
    assign station_number    = station_ff;
    assign bit_rate_code     = rate_ff;
    assign parity_enable     = par_en_ff;
    assign parity_odd        = par_odd_ff;
    assign two_stop_bits     = two_stop_ff;
    assign motor_run         = run_ff;
    assign ramp_freeze       = hold_ff;
    assign ramp_complete     = complete_ff;
    assign fault_reset       = fault_reset_ff;
    assign tripped           = tripped_ff;
    assign preset_code       = preset_ff;
    assign preset_load       = preset_load_ff;
    assign auto_torque       = torque_ff;
    assign finish_on_current = fin_cur_ff;
    assign finish_on_speed   = fin_spd_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // even code taken from the field itself, so the parity check does not trust its own outputs
    logic parity_code_ok;
    assign parity_code_ok = parity_ff == `PARITY_EVEN;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence clr_high_low;
        clr_cmd_ff ##1 !clr_cmd_ff;
    endsequence

    a_station_range: assert property (
        station_number >= `STATION_MIN && station_number <= `STATION_MAX)
        else $error("station number out of range");
    a_foreign_silent: assert property (
        req_valid && ({8'h00, req.station} != station_number) |=> !rsp_valid)
        else $error("answered a foreign station");
    a_rate_range: assert property (
        bit_rate_code <= `RATE_MAX)
        else $error("bit rate code out of range");
    a_parity_frame: assert property (
        parity_enable == (parity_odd || (parity_code_ok && !parity_odd)))
        else $error("parity outputs inconsistent");
    a_stop_bits: assert property (
        two_stop_bits == !parity_enable)
        else $error("stop bits do not follow parity");
    a_run_write: assert property (
        wr_ok && sel_run |=> motor_run == $past(req.wdata[0]))
        else $error("run command not taken");
    a_hold_blocks: assert property (
        hold_ff |=> !ramp_complete)
        else $error("ramp finished while held");
    a_hold_current: assert property (
        hold_ff && ramp_active && finish_on_current && current_below_limit |=> !ramp_complete)
        else $error("current finish overrode hold");
    a_clear_pulse: assert property (
        clr_high_low |=> fault_reset ##1 !fault_reset)
        else $error("fault reset pulse missing");
    a_trip_set: assert property (
        remote_trip_enable && trip_cmd_ff |=> tripped)
        else $error("remote trip not taken");
    a_preset_load: assert property (
        wr_ok && sel_preset |=> preset_load && preset_code == $past(req.wdata))
        else $error("preset load not signalled");
    a_speed_finish: assert property (
        ramp_active && !hold_ff && finish_on_speed && at_full_speed |=> ramp_complete)
        else $error("speed finish missed");
    a_time_only: assert property (
        ramp_active && !start_time_done && !finish_on_current && !finish_on_speed
        |=> !ramp_complete)
        else $error("ramp ended before start time");
    a_bad_value: assert property (
        hit && req.write && known && !val_ok |=> rsp_valid && rsp.err && $stable(motor_run))
        else $error("bad value not refused");

endmodule

// *** ss_master_model.sv ***
// behavioural serial master that issues parameter requests to the bank
`timescale 1ns/1ps
`include "ss_params_defines.svh"

module ss_master_model (
    input  wire logic           ref_clk,
    input  wire logic           parity_enable,
    output logic                req_valid,
    output ss_params_pkg::req_s req
);
    logic [1:0] frame_stop_bits;

    // master framing follows the parity the bank runs with
    assign frame_stop_bits = parity_enable ? 2'h1 : 2'h2;

    initial begin
        req_valid = 1'b0;
        req = '0;
    end

    // one request held for one cycle; a released bus shows the inverse, not stale data
    task automatic send(input logic w, input logic [7:0] st, input logic [15:0] pn,
                        input logic [15:0] wd);
        @(negedge ref_clk);
        req_valid <= 1'b1;
        req <= '{write: w, station: st, param: pn, wdata: wd};
        @(negedge ref_clk);
        req_valid <= 1'b0;
        req <= ss_params_pkg::req_s'(~req);
    endtask

    // fault clear is a high then low pulse on back-to-back cycles
    task automatic clear_pulse(input logic [7:0] st);
        @(negedge ref_clk);
        req_valid <= 1'b1;
        req <= '{write: 1'b1, station: st, param: `PN_CLEAR, wdata: 16'h0001};
        @(negedge ref_clk);
        req.wdata <= 16'h0000;
        @(negedge ref_clk);
        req_valid <= 1'b0;
        req <= ss_params_pkg::req_s'(~req);
    endtask
endmodule

// *** soft_starter_modbus_params_tb_top.sv ***
// self-checking bench of the soft starter parameter bank
`timescale 1ns/1ps
`include "ss_params_defines.svh"
`define CHK(a, b, m) begin \
    samples_checked++; \
    if ((a) !== (b)) begin \
        error_cnt++; \
        $display("MISMATCH t=%0t %s", $time, m); \
    end \
end

module soft_starter_modbus_params_tb_top;
    logic                ref_clk, reset_n, req_valid, rsp_valid;
    ss_params_pkg::req_s req;
    ss_params_pkg::rsp_s rsp;
    logic                remote_trip_enable, ramp_active, start_time_done;
    logic                current_below_limit, at_full_speed;
    logic [15:0]         station_number, bit_rate_code, preset_code, v;
    logic                parity_enable, parity_odd, two_stop_bits, motor_run, ramp_freeze;
    logic                ramp_complete, fault_reset, tripped, preset_load, auto_torque;
    logic                finish_on_current, finish_on_speed, exp_done;
    logic [7:0]          st;
    int                  error_cnt = 0;
    int                  samples_checked = 0;
    int                  pulses;
    ss_params_pkg::rsp_s exp_q[$];
    logic [15:0] pns [11] = '{`PN_STATION, `PN_RATE, `PN_PARITY, `PN_RUN, `PN_HOLD,
        `PN_CLEAR, `PN_TRIP, `PN_PRESET, `PN_TORQUE, `PN_FIN_CUR, `PN_FIN_SPD};
    logic [15:0] rsts [11] = '{16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] bit_pns [5] = '{`PN_RUN, `PN_HOLD, `PN_TORQUE, `PN_FIN_CUR, `PN_FIN_SPD};

    soft_starter_modbus_params dut (.ref_clk, .reset_n, .req_valid, .req, .rsp_valid, .rsp,
        .remote_trip_enable, .ramp_active, .start_time_done, .current_below_limit,
        .at_full_speed, .station_number, .bit_rate_code, .parity_enable, .parity_odd,
        .two_stop_bits, .motor_run, .ramp_freeze, .ramp_complete, .fault_reset, .tripped,
        .preset_code, .preset_load, .auto_torque, .finish_on_current, .finish_on_speed);

    ss_master_model mst (.ref_clk, .parity_enable, .req_valid, .req);

    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    // every answer is matched against the oldest expectation the driver noted
    always @(negedge ref_clk) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) `CHK(1'b1, 1'b0, "unexpected answer")
            else `CHK(rsp, exp_q.pop_front(), "answer")
        end
    end

    task automatic xact(input logic w, input logic [15:0] pn, input logic [15:0] wd,
                        input logic [7:0] code, input logic [15:0] rd);
        exp_q.push_back('{err: code != 8'h00, code: code, rdata: rd});
        mst.send(w, st, pn, wd);
    endtask

    task automatic idle();
        repeat (2) @(negedge ref_clk);
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // hang guard: the sequence needs a few thousand cycles at most
    initial begin
        #200000;
        error_cnt++;
        conclude();
    end

    initial begin
        void'($urandom(90));
        {remote_trip_enable, ramp_active, start_time_done} = 3'h0;
        {current_below_limit, at_full_speed} = 2'h0;
        reset_n = 1'b0;
        st = 8'h01;
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk) reset_n = 1'b1;
        `CHK({parity_enable, parity_odd, two_stop_bits}, 3'b100, "reset framing")
        for (int i = 0; i < 11; i++) xact(1'b0, pns[i], 16'h0, 8'h00, rsts[i]);
        xact(1'b0, 16'h3f40, 16'h0, `EXC_ADDR, 16'h0);
        // station range, new station answers, old station ignored
        xact(1'b1, `PN_STATION, 16'h0000, `EXC_VALUE, 16'h0);
        xact(1'b1, `PN_STATION, 16'h0021, `EXC_VALUE, 16'h0);
        xact(1'b1, `PN_STATION, 16'h0020, 8'h00, 16'h0);
        `CHK(station_number, 16'h0020, "station")
        st = 8'h20;
        mst.send(1'b0, 8'h01, `PN_STATION, 16'h0);
        xact(1'b0, `PN_STATION, 16'h0, 8'h00, 16'h0020);
        xact(1'b1, `PN_STATION, 16'h0001, 8'h00, 16'h0);
        st = 8'h01;
        for (int i = 0; i < 6; i++) begin
            xact(1'b1, `PN_RATE, 16'(i), (i == 5) ? `EXC_VALUE : 8'h00, 16'h0);
            idle();
            `CHK(bit_rate_code, (i == 5) ? 16'h4 : 16'(i), "rate")
        end
        for (int i = 0; i < 4; i++) begin
            xact(1'b1, `PN_PARITY, 16'(i), (i == 3) ? `EXC_VALUE : 8'h00, 16'h0);
            idle();
            v = (i == 3) ? 16'h2 : 16'(i);
            `CHK({parity_enable, parity_odd, two_stop_bits}, {v != 0, v == 2, v == 0},
                "par")
            `CHK(mst.frame_stop_bits, (v == 16'h0) ? 2'h2 : 2'h1, "framing")
        end
        // single bit fields: out of range refused, then set and clear
        for (int i = 0; i < 5; i++) begin
            xact(1'b1, bit_pns[i], 16'h2 + 16'($urandom_range(500)), `EXC_VALUE,
                16'h0);
            xact(1'b1, bit_pns[i], 16'h1, 8'h00, 16'h0);
            xact(1'b0, bit_pns[i], 16'h0, 8'h00, 16'h1);
        end
        idle();
        `CHK({motor_run, ramp_freeze, auto_torque, finish_on_current, finish_on_speed},
            5'h1f, "bits")
        for (int i = 0; i < 5; i++) xact(1'b1, bit_pns[i], 16'h0, 8'h00, 16'h0);
        idle();
        `CHK({motor_run, ramp_freeze, auto_torque, finish_on_current, finish_on_speed},
            5'h00, "bits")
        // ramp completion for every hold and finish option combination
        for (int c = 0; c < 8; c++) begin
            xact(1'b1, `PN_HOLD, 16'(c & 1), 8'h00, 16'h0);
            xact(1'b1, `PN_FIN_CUR, 16'((c >> 1) & 1), 8'h00, 16'h0);
            xact(1'b1, `PN_FIN_SPD, 16'((c >> 2) & 1), 8'h00, 16'h0);
            idle();
            for (int k = 0; k < 13; k++) begin
                exp_done = ramp_active & !c[0] & (start_time_done | c[1] & current_below_limit
                    | c[2] & at_full_speed);
                @(negedge ref_clk);
                `CHK(ramp_complete, exp_done, "ramp")
                {ramp_active, start_time_done, current_below_limit, at_full_speed} = 4'($urandom);
            end
        end
        // remote trip needs the enable; clear after the trip command is low
        xact(1'b1, `PN_TRIP, 16'h1, 8'h00, 16'h0);
        idle();
        `CHK(tripped, 1'b0, "trip without enable")
        remote_trip_enable = 1'b1;
        idle();
        `CHK(tripped, 1'b1, "trip")
        xact(1'b1, `PN_TRIP, 16'h0, 8'h00, 16'h0);
        xact(1'b1, `PN_RUN, 16'h0, 8'h00, 16'h0);
        exp_q.push_back('0);
        exp_q.push_back('0);
        pulses = 0;
        fork
            mst.clear_pulse(st);
            repeat (9) @(negedge ref_clk) pulses += int'(fault_reset === 1'b1);
        join
        `CHK(pulses, 1, "clear pulse")
        `CHK(tripped, 1'b0, "trip cleared")
        // preset load pulses once with the new code in place
        v = 16'($urandom);
        exp_q.push_back('0);
        pulses = 0;
        fork
            mst.send(1'b1, st, `PN_PRESET, v);
            repeat (4) @(negedge ref_clk) pulses += int'(preset_load === 1'b1);
        join
        `CHK(pulses, 1, "preset pulse")
        `CHK(preset_code, v, "preset code")
        idle();
        `CHK(exp_q.size(), 0, "missing answers")
        conclude();
    end
endmodule
